// [spsmp_pkg.sv]
package spsmp_pkg;

  // core clock and self-timed write delays
  localparam int unsigned CORE_HZ    = 25_000_000;
  localparam int unsigned HZ_PER_MHZ = 1_000_000;
  localparam int unsigned T_FLASH_US = 5000;
  localparam int unsigned T_EE_US    = 10000;
  localparam int unsigned T_FUSE_US  = 4500;
  localparam int unsigned T_ERASE_US = 10000;
  localparam int unsigned FLASH_CYC  = T_FLASH_US * (CORE_HZ / HZ_PER_MHZ);
  localparam int unsigned EE_CYC     = T_EE_US * (CORE_HZ / HZ_PER_MHZ);
  localparam int unsigned FUSE_CYC   = T_FUSE_US * (CORE_HZ / HZ_PER_MHZ);
  localparam int unsigned ERASE_CYC  = T_ERASE_US * (CORE_HZ / HZ_PER_MHZ);
  localparam int unsigned CNT_W      = 18;
  typedef logic [CNT_W-1:0] spsmp_cnt_t;

  // array geometry
  localparam int unsigned FLASH_AW = 16;
  localparam int unsigned EE_AW    = 12;
  localparam int unsigned PAGE_AW  = 7;

  // instruction bytes
  localparam logic [7:0] OP_ENTRY    = 8'hAC;
  localparam logic [7:0] OP_ENTRY2   = 8'h53;
  localparam logic [7:0] OP_HMASK    = 8'hF7;
  localparam int unsigned H_BIT      = 3;
  localparam logic [7:0] OP_RD_FLASH = 8'h20;
  localparam logic [7:0] OP_LD_PAGE  = 8'h40;
  localparam logic [7:0] OP_WR_PAGE  = 8'h4C;
  localparam logic [7:0] OP_RD_EE    = 8'hA0;
  localparam logic [7:0] OP_WR_EE    = 8'hC0;
  localparam logic [7:0] OP_RD_LOCK  = 8'h58;
  localparam logic [7:0] OP_RD_FUSE  = 8'h50;
  localparam logic [7:0] OP_RD_SIG   = 8'h30;
  localparam logic [7:0] OP_RD_CAL   = 8'h38;
  localparam logic [7:0] SUB_FUSE_LO = 8'hA0;
  localparam logic [7:0] SUB_FUSE_HI = 8'hA8;
  localparam logic [7:0] SUB_FUSE_EX = 8'hA4;
  localparam logic [7:0] SUB_RD_LO   = 8'h00;
  localparam logic [7:0] SUB_RD_HI   = 8'h08;
  localparam logic [2:0] SUB_ERASE   = 3'h4;
  localparam logic [2:0] SUB_LOCK    = 3'h7;

  // values
  localparam logic [7:0] ERASED   = 8'hFF;
  localparam logic [7:0] FUSE_RST = 8'hFF;
  localparam logic [4:0] BIT_ECHO = 5'h10;
  localparam logic [4:0] BIT_HDR  = 5'h17;
  localparam logic [4:0] BIT_READ = 5'h18;
  localparam logic [4:0] BIT_LAST = 5'h1F;
  // sync inputs: bit 0 reset pin, 1 strap, 2 header toggle, 3 word toggle
  localparam logic [3:0] SYNC_RST = 4'h3;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_PAGE   = 3'b001,
    ST_EEPROM = 3'b010,
    ST_FUSE   = 3'b011,
    ST_ERASE  = 3'b100
  } spsmp_state_t;

endpackage : spsmp_pkg

// [spsmp_serial_prog.sv]
// Function
// - programming accepted while reset pin low or in a strap session; release ends a pin session
// - serial data uses the dedicated programming in/out pins only
// - eeprom byte write replaces the location at the end of the self-timed write, with no separate erase
// - chip erase sets every flash and eeprom location to all ones
// - serial input sampled on rising serial clock edge
// - serial output changes on falling serial clock edge
// - strap low at power-on reset selects programming until power cycle
// - second enable byte echoes out while the third byte is received
// - page buffer loaded by 7 low address bits, low byte before high
// - page write commits buffer to page chosen by upper 9 address bits
// - read instructions return the addressed location on serial out
// - reads inside a page being programmed return all ones until done
// - reads of an eeprom byte being programmed return all ones until done
// - enable instruction is AC 53 followed by two don't-care bytes
// - chip erase is AC then a byte whose top bits are 100
`timescale 1ns/1ps
`default_nettype none

module spsmp_serial_prog #(
  parameter int unsigned FLASH_AW  = spsmp_pkg::FLASH_AW,
  parameter int unsigned EE_AW     = spsmp_pkg::EE_AW,
  parameter int unsigned FLASH_CYC = spsmp_pkg::FLASH_CYC,
  parameter int unsigned EE_CYC    = spsmp_pkg::EE_CYC,
  parameter int unsigned FUSE_CYC  = spsmp_pkg::FUSE_CYC,
  parameter int unsigned ERASE_CYC = spsmp_pkg::ERASE_CYC,
  // identity values are arbitrary
  parameter logic [7:0]  SIG0      = 8'h1E,
  parameter logic [7:0]  SIG1      = 8'h77,
  parameter logic [7:0]  SIG2      = 8'h2B,
  parameter logic [7:0]  CAL_BYTE  = 8'h80
) (
  // core clock and reset
  input  wire logic CLK_SYS,
  input  wire logic SRST,
  // programming pins
  input  wire logic RESET_PIN_N,
  input  wire logic SERIAL_PROG_ENTRY_STRAP_N,
  input  wire logic SERIAL_CLOCK,
  input  wire logic PROG_SERIAL_IN,
  output logic      PROG_SERIAL_OUT,
  output logic      PROG_SERIAL_OUT_OE_N,
  // status
  output logic      PROG_MODE,
  output logic      PROG_BUSY
);

  localparam int unsigned PAGE_AW = spsmp_pkg::PAGE_AW;

  function automatic logic hop(input logic [7:0] b, input logic [7:0] base);
    hop = (b & spsmp_pkg::OP_HMASK) == base;
  endfunction : hop

  //////////////////////////////////////////////////////////////////////////////
  // link side, clocked by the programmer's serial clock

  logic                     link_clr_q;
  logic [4:0]               bcnt_q;
  logic [30:0]              sin_q;
  logic [23:0]              hdr_q;
  logic [31:0]              word_q;
  logic                     hdr_tgl_q;
  logic                     word_tgl_q;
  logic [7:0]               sout_q;
  logic [7:0]               rd_data_q;

  // cleared only while out of session, so a lost bit is fixed by a reset pulse
  always_ff @(posedge SERIAL_CLOCK or posedge link_clr_q) begin
    if (link_clr_q) begin
      bcnt_q <= 5'h00;
      sin_q  <= 31'h00000000;
    end else begin
      bcnt_q <= bcnt_q + 5'h01;
      sin_q  <= {sin_q[29:0], PROG_SERIAL_IN};
    end
  end

  always_ff @(posedge SERIAL_CLOCK or posedge link_clr_q) begin
    if (link_clr_q) begin
      hdr_q      <= 24'h000000;
      word_q     <= 32'h00000000;
      hdr_tgl_q  <= 1'b0;
      word_tgl_q <= 1'b0;
    end else begin
      if (bcnt_q == spsmp_pkg::BIT_HDR) begin
        hdr_q     <= {sin_q[22:0], PROG_SERIAL_IN};
        hdr_tgl_q <= ~hdr_tgl_q;
      end
      if (bcnt_q == spsmp_pkg::BIT_LAST) begin
        word_q     <= {sin_q[30:0], PROG_SERIAL_IN};
        word_tgl_q <= ~word_tgl_q;
      end
    end
  end

  // rd_data_q is held stable by the core once the header toggle is answered
  always_ff @(negedge SERIAL_CLOCK or posedge link_clr_q) begin
    if (link_clr_q) begin
      sout_q <= 8'h00;
    end else if (bcnt_q == spsmp_pkg::BIT_ECHO) begin
      sout_q <= sin_q[7:0];
    end else if (bcnt_q == spsmp_pkg::BIT_READ) begin
      sout_q <= rd_data_q;
    end else begin
      sout_q <= {sout_q[6:0], 1'b0};
    end
  end

  assign PROG_SERIAL_OUT = sout_q[7];

  //////////////////////////////////////////////////////////////////////////////
  // pin and toggle synchronisers

  logic [3:0]               ain;
  logic [3:0]               sy1_q;
  logic [3:0]               sy2_q;
  logic [3:0]               sy3_q;
  logic [3:0]               flt_q;
  logic [3:0]               fprev_q;

  assign ain = {word_tgl_q, hdr_tgl_q, SERIAL_PROG_ENTRY_STRAP_N, RESET_PIN_N};

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      sy1_q   <= spsmp_pkg::SYNC_RST;
      sy2_q   <= spsmp_pkg::SYNC_RST;
      sy3_q   <= spsmp_pkg::SYNC_RST;
      flt_q   <= spsmp_pkg::SYNC_RST;
      fprev_q <= spsmp_pkg::SYNC_RST;
    end else begin
      sy1_q   <= ain;
      sy2_q   <= sy1_q;
      sy3_q   <= sy2_q;
      flt_q   <= (sy2_q & sy3_q) | (flt_q & (sy2_q | sy3_q));
      fprev_q <= flt_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // session control

  logic [2:0]               por_cnt_q;
  logic                     strap_mode_q;
  logic                     sess;
  logic [1:0]               guard_q;
  logic                     hevt;
  logic                     wevt;
  logic                     enabled_q;

  // strap counts only as caught after power-on reset, once its synchroniser has settled
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      por_cnt_q    <= 3'h0;
      strap_mode_q <= 1'b0;
    end else if (por_cnt_q != 3'h7) begin
      por_cnt_q <= por_cnt_q + 3'h1;
      if (por_cnt_q == 3'h6) begin
        strap_mode_q <= ~flt_q[1];
      end
    end
  end

  assign sess = strap_mode_q | (~flt_q[0] & (por_cnt_q == 3'h7));

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      link_clr_q <= 1'b1;
      guard_q    <= 2'h0;
    end else begin
      link_clr_q <= ~sess;
      if (link_clr_q) begin
        guard_q <= 2'h0;
      end else if (guard_q != 2'h3) begin
        guard_q <= guard_q + 2'h1;
      end
    end
  end

  // the guard hides toggles that fall back when the link is cleared
  assign hevt = sess && (guard_q == 2'h3) && (flt_q[2] != fprev_q[2]);
  assign wevt = sess && (guard_q == 2'h3) && (flt_q[3] != fprev_q[3]);

  always_ff @(posedge CLK_SYS) begin
    if (SRST || !sess) begin
      enabled_q <= 1'b0;
    end else if (wevt && word_q[31:24] == spsmp_pkg::OP_ENTRY &&
                 word_q[23:16] == spsmp_pkg::OP_ENTRY2) begin
      enabled_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      PROG_MODE            <= 1'b0;
      PROG_SERIAL_OUT_OE_N <= 1'b1;
    end else begin
      PROG_MODE            <= sess;
      PROG_SERIAL_OUT_OE_N <= ~sess;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // instruction decode and self-timed writes

  logic [7:0]               b1;
  logic [7:0]               b2;
  logic [7:0]               b3;
  logic [7:0]               b4;
  logic [15:0]              wa;
  logic                     go;
  spsmp_pkg::spsmp_state_t  st_q;
  spsmp_pkg::spsmp_cnt_t    cnt_q;
  logic [FLASH_AW-1:0]      walk_q;
  logic                     wdone_q;
  logic [FLASH_AW-PAGE_AW-1:0] page_q;
  logic [EE_AW-1:0]         ee_addr_q;
  logic [7:0]               ee_data_q;
  logic [7:0]               fuse_lo_q;
  logic [7:0]               fuse_hi_q;
  logic [7:0]               fuse_ex_q;
  logic [7:0]               lock_q;

  assign b1 = word_q[31:24];
  assign b2 = word_q[23:16];
  assign b3 = word_q[15:8];
  assign b4 = word_q[7:0];
  assign wa = word_q[23:8];
  // non-read instructions while busy are dropped rather than corrupt a write
  assign go = wevt && enabled_q && (st_q == spsmp_pkg::ST_IDLE);

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      st_q    <= spsmp_pkg::ST_IDLE;
      cnt_q   <= '0;
      walk_q  <= '0;
      wdone_q <= 1'b0;
    end else begin
      unique case (st_q)
        spsmp_pkg::ST_IDLE: begin
          walk_q  <= '0;
          wdone_q <= 1'b0;
          if (go && b1 == spsmp_pkg::OP_ENTRY && b2[7:5] == spsmp_pkg::SUB_ERASE) begin
            st_q  <= spsmp_pkg::ST_ERASE;
            cnt_q <= spsmp_pkg::spsmp_cnt_t'(ERASE_CYC);
          end else if (go && b1 == spsmp_pkg::OP_ENTRY && b2 != spsmp_pkg::OP_ENTRY2) begin
            st_q    <= spsmp_pkg::ST_FUSE;
            cnt_q   <= spsmp_pkg::spsmp_cnt_t'(FUSE_CYC);
            wdone_q <= 1'b1;
          end else if (go && b1 == spsmp_pkg::OP_WR_PAGE) begin
            st_q  <= spsmp_pkg::ST_PAGE;
            cnt_q <= spsmp_pkg::spsmp_cnt_t'(FLASH_CYC);
          end else if (go && b1 == spsmp_pkg::OP_WR_EE) begin
            st_q    <= spsmp_pkg::ST_EEPROM;
            cnt_q   <= spsmp_pkg::spsmp_cnt_t'(EE_CYC);
            wdone_q <= 1'b1;
          end
        end
        spsmp_pkg::ST_PAGE, spsmp_pkg::ST_EEPROM,
        spsmp_pkg::ST_FUSE, spsmp_pkg::ST_ERASE: begin
          // timed on the core clock whatever the serial clock does
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end
          if (!wdone_q) begin
            walk_q  <= walk_q + 1'b1;
            wdone_q <= (st_q == spsmp_pkg::ST_PAGE) ? (&walk_q[PAGE_AW-1:0]) : (&walk_q);
          end
          if (cnt_q == '0 && wdone_q) begin
            st_q <= spsmp_pkg::ST_IDLE;
          end
        end
        default: st_q <= spsmp_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      PROG_BUSY <= 1'b0;
    end else begin
      PROG_BUSY <= (st_q != spsmp_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      page_q    <= '0;
      ee_addr_q <= '0;
      ee_data_q <= 8'h00;
    end else if (go) begin
      if (b1 == spsmp_pkg::OP_WR_PAGE) begin
        page_q <= wa[FLASH_AW-1:PAGE_AW];
      end
      if (b1 == spsmp_pkg::OP_WR_EE) begin
        ee_addr_q <= wa[EE_AW-1:0];
        ee_data_q <= b4;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      fuse_lo_q <= spsmp_pkg::FUSE_RST;
      fuse_hi_q <= spsmp_pkg::FUSE_RST;
      fuse_ex_q <= spsmp_pkg::FUSE_RST;
      lock_q    <= spsmp_pkg::FUSE_RST;
    end else if (st_q == spsmp_pkg::ST_ERASE) begin
      lock_q <= spsmp_pkg::ERASED;
    end else if (go && b1 == spsmp_pkg::OP_ENTRY) begin
      if (b2 == spsmp_pkg::SUB_FUSE_LO) fuse_lo_q <= b4;
      if (b2 == spsmp_pkg::SUB_FUSE_HI) fuse_hi_q <= b4;
      if (b2 == spsmp_pkg::SUB_FUSE_EX) fuse_ex_q <= b4;
      if (b2[7:5] == spsmp_pkg::SUB_LOCK) lock_q <= b4;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // arrays

  logic [7:0]               pbuf_lo [2**PAGE_AW];
  logic [7:0]               pbuf_hi [2**PAGE_AW];
  logic [15:0]              flash_mem [2**FLASH_AW];
  logic [7:0]               ee_mem [2**EE_AW];

  // the high byte is taken as is; the programmer orders low before high
  always_ff @(posedge CLK_SYS) begin
    if (go && hop(b1, spsmp_pkg::OP_LD_PAGE)) begin
      if (b1[spsmp_pkg::H_BIT]) begin
        pbuf_hi[b3[PAGE_AW-1:0]] <= b4;
      end else begin
        pbuf_lo[b3[PAGE_AW-1:0]] <= b4;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (st_q == spsmp_pkg::ST_PAGE && !wdone_q) begin
      flash_mem[{page_q, walk_q[PAGE_AW-1:0]}] <=
        {pbuf_hi[walk_q[PAGE_AW-1:0]], pbuf_lo[walk_q[PAGE_AW-1:0]]};
    end
    if (st_q == spsmp_pkg::ST_ERASE && !wdone_q) begin
      flash_mem[walk_q] <= {spsmp_pkg::ERASED, spsmp_pkg::ERASED};
      if ((walk_q >> EE_AW) == '0) begin
        ee_mem[walk_q[EE_AW-1:0]] <= spsmp_pkg::ERASED;
      end
    end
    // new value lands at the end of the self-timed cycle, replacing the old
    if (st_q == spsmp_pkg::ST_EEPROM && cnt_q == '0) begin
      ee_mem[ee_addr_q] <= ee_data_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read answer, held until the next header

  logic [7:0]               h1;
  logic [7:0]               h2;
  logic [7:0]               h3;
  logic [15:0]              ha;
  logic [15:0]              fword;

  assign h1    = hdr_q[23:16];
  assign h2    = hdr_q[15:8];
  assign h3    = hdr_q[7:0];
  assign ha    = hdr_q[15:0];
  assign fword = flash_mem[ha[FLASH_AW-1:0]];

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      rd_data_q <= 8'h00;
    end else if (hevt) begin
      if (hop(h1, spsmp_pkg::OP_RD_FLASH)) begin
        if (st_q == spsmp_pkg::ST_ERASE ||
            (st_q == spsmp_pkg::ST_PAGE && ha[FLASH_AW-1:PAGE_AW] == page_q)) begin
          rd_data_q <= spsmp_pkg::ERASED;
        end else begin
          rd_data_q <= h1[spsmp_pkg::H_BIT] ? fword[15:8] : fword[7:0];
        end
      end else if (h1 == spsmp_pkg::OP_RD_EE) begin
        if (st_q == spsmp_pkg::ST_ERASE ||
            (st_q == spsmp_pkg::ST_EEPROM && ha[EE_AW-1:0] == ee_addr_q)) begin
          rd_data_q <= spsmp_pkg::ERASED;
        end else begin
          rd_data_q <= ee_mem[ha[EE_AW-1:0]];
        end
      end else if (h1 == spsmp_pkg::OP_RD_FUSE) begin
        rd_data_q <= (h2 == spsmp_pkg::SUB_RD_HI) ? fuse_ex_q : fuse_lo_q;
      end else if (h1 == spsmp_pkg::OP_RD_LOCK) begin
        rd_data_q <= (h2 == spsmp_pkg::SUB_RD_LO) ? lock_q : fuse_hi_q;
      end else if (h1 == spsmp_pkg::OP_RD_SIG) begin
        rd_data_q <= (h3[1:0] == 2'h0) ? SIG0 : (h3[1:0] == 2'h1) ? SIG1 : SIG2;
      end else if (h1 == spsmp_pkg::OP_RD_CAL) begin
        rd_data_q <= CAL_BYTE;
      end else begin
        rd_data_q <= 8'h00;
      end
    end
  end

endmodule : spsmp_serial_prog

`default_nettype wire

// [spsmp_serial_prog_checker.sv]
`timescale 1ns/1ps
`default_nettype none

module spsmp_serial_prog_checker #(
  parameter int unsigned FLASH_AW  = spsmp_pkg::FLASH_AW,
  parameter int unsigned FLASH_CYC = spsmp_pkg::FLASH_CYC,
  parameter int unsigned EE_CYC    = spsmp_pkg::EE_CYC,
  parameter int unsigned FUSE_CYC  = spsmp_pkg::FUSE_CYC,
  parameter int unsigned ERASE_CYC = spsmp_pkg::ERASE_CYC
) (
  // core clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // programming pins
  input wire logic RESET_PIN_N,
  input wire logic SERIAL_PROG_ENTRY_STRAP_N,
  input wire logic SERIAL_CLOCK,
  input wire logic PROG_SERIAL_IN,
  input wire logic PROG_SERIAL_OUT,
  input wire logic PROG_SERIAL_OUT_OE_N,
  // status
  input wire logic PROG_MODE,
  input wire logic PROG_BUSY
);
  localparam int unsigned ER_LEN = (ERASE_CYC > (1 << FLASH_AW)) ?
                                   ERASE_CYC + 1 : (1 << FLASH_AW) + 1;
  localparam int unsigned MIN_A  = (FLASH_CYC < EE_CYC) ? FLASH_CYC + 1 : EE_CYC + 1;
  localparam int unsigned MIN_B  = (MIN_A < FUSE_CYC) ? MIN_A : FUSE_CYC;
  localparam int unsigned MIN_BSY = (MIN_B < ER_LEN) ? MIN_B : ER_LEN;
  localparam int unsigned MAX_A  = (FLASH_CYC > EE_CYC) ? FLASH_CYC + 1 : EE_CYC + 1;
  localparam int unsigned MAX_B  = (MAX_A > FUSE_CYC + 1) ? MAX_A : FUSE_CYC + 1;
  localparam int unsigned MAX_BSY = (MAX_B > ER_LEN) ? MAX_B : ER_LEN;

  //////////////////////////////////////////////////
  // length of the current busy run, in core cycles
  logic [31:0] busy_run_q;
  always_ff @(posedge CLK_SYS) begin
    if (SRST || !PROG_BUSY) begin
      busy_run_q <= 32'h0;
    end else begin
      busy_run_q <= busy_run_q + 32'h1;
    end
  end

  // strap level held at power-on reset; a strap session ignores the reset pin
  logic strap_entry_q;
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      strap_entry_q <= !SERIAL_PROG_ENTRY_STRAP_N;
    end
  end

  //////////////////////////////////////////////////
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  sequence s_pin_low;
    $fell(RESET_PIN_N) ##1 (!RESET_PIN_N) [*7];
  endsequence
  sequence s_pin_high;
    (RESET_PIN_N && !strap_entry_q) [*8];
  endsequence

  // the reset check itself must not be switched off by the reset
  a_reset_quiet: assert property (disable iff (1'b0) SRST |=> !PROG_MODE && !PROG_BUSY
    && PROG_SERIAL_OUT_OE_N && !PROG_SERIAL_OUT) else $error("outputs active after reset");
  a_mode_entry: assert property (s_pin_low |-> PROG_MODE)
    else $error("no session while reset pin low");
  a_mode_exit: assert property (s_pin_high |-> ##2 !PROG_MODE)
    else $error("session kept after reset pin high");
  a_oe_mode: assert property (PROG_SERIAL_OUT_OE_N == !PROG_MODE)
    else $error("output enable does not follow session");
  a_busy_session: assert property ($rose(PROG_BUSY) |-> PROG_MODE)
    else $error("write started outside a session");
  a_busy_short: assert property ($fell(PROG_BUSY) |-> busy_run_q >= MIN_BSY)
    else $error("self-timed write ended early");
  a_busy_long: assert property (PROG_BUSY |-> busy_run_q < MAX_BSY)
    else $error("self-timed write runs too long");
  a_out_on_fall: assert property ($changed(PROG_SERIAL_OUT) |-> !SERIAL_CLOCK)
    else $error("serial out moved while clock high");
  a_out_idle_low: assert property ((!PROG_MODE) [*4] |-> !PROG_SERIAL_OUT)
    else $error("serial out active outside session");
endmodule : spsmp_serial_prog_checker

bind spsmp_serial_prog spsmp_serial_prog_checker #(
  .FLASH_AW(FLASH_AW), .FLASH_CYC(FLASH_CYC), .EE_CYC(EE_CYC),
  .FUSE_CYC(FUSE_CYC), .ERASE_CYC(ERASE_CYC)
) i_chk (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .RESET_PIN_N(RESET_PIN_N),
  .SERIAL_PROG_ENTRY_STRAP_N(SERIAL_PROG_ENTRY_STRAP_N), .SERIAL_CLOCK(SERIAL_CLOCK),
  .PROG_SERIAL_IN(PROG_SERIAL_IN), .PROG_SERIAL_OUT(PROG_SERIAL_OUT),
  .PROG_SERIAL_OUT_OE_N(PROG_SERIAL_OUT_OE_N), .PROG_MODE(PROG_MODE), .PROG_BUSY(PROG_BUSY)
);

`default_nettype wire

// [spsmp_prog_model.sv]
`timescale 1ns/1ps
`default_nettype none

module spsmp_prog_model #(
  parameter int HALF = 135,
  parameter int HOLD = 330
) (
  // serial link
  output logic     sck,
  output logic     mosi,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
  end

  // answer bits are taken at the rise since the device moves them at the fall
  task automatic xfer(input logic [31:0] ins, input int nbits,
                      output logic [7:0] echo, output logic [7:0] rd);
    int i;
    echo = 8'h00;
    rd = 8'h00;
    #7;
    for (i = 31; i >= 32 - nbits; i--) begin
      mosi = ins[i];
      #(HALF);
      sck = 1'b1;
      if (i >= 8 && i < 16) echo = {echo[6:0], miso};
      if (i < 8) rd = {rd[6:0], miso};
      // long high after bit 24 lets the read answer reach the shifter
      #((i == 8) ? HOLD : HALF);
      sck = 1'b0;
    end
    // a released data line must not keep showing the last bit
    mosi = ~mosi;
  endtask : xfer
endmodule : spsmp_prog_model

`default_nettype wire

// [test_spsmp_serial_prog.sv]
`timescale 1ns/1ps
`default_nettype none

module test_spsmp_serial_prog;
  localparam int FAW = 10;
  localparam int WCYC = 2000;
  localparam int ER_LEN = (WCYC > (1 << FAW)) ? WCYC : (1 << FAW);

  logic       clk_sys = 1'b0;
  logic       srst = 1'b1;
  logic       reset_pin_n = 1'b1;
  logic       strap_n = 1'b1;
  logic       flip = 1'b0;
  logic       sck;
  logic       mosi;
  logic       sout;
  logic       sout_oe_n;
  logic       mode;
  logic       busy;
  wire        miso;
  int         bad_count = 0;
  int         n_checks = 0;
  int         seed = 32'hD67CA0D8;
  logic [7:0] ee_m [int];

  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) flip <= ~flip;
  // undriven answer line wanders rather than holding a stale bit
  assign miso = sout_oe_n ? flip : sout;

  spsmp_serial_prog #(
    .FLASH_AW(FAW), .EE_AW(8), .FLASH_CYC(WCYC),
    .EE_CYC(WCYC), .FUSE_CYC(WCYC), .ERASE_CYC(WCYC)
  ) i_dut (
    .CLK_SYS(clk_sys), .SRST(srst), .RESET_PIN_N(reset_pin_n),
    .SERIAL_PROG_ENTRY_STRAP_N(strap_n), .SERIAL_CLOCK(sck), .PROG_SERIAL_IN(mosi),
    .PROG_SERIAL_OUT(sout), .PROG_SERIAL_OUT_OE_N(sout_oe_n), .PROG_MODE(mode),
    .PROG_BUSY(busy)
  );

  spsmp_prog_model i_prog (.sck(sck), .mosi(mosi), .miso(miso));

  //////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic ins(input logic [31:0] w, output logic [7:0] e, output logic [7:0] r);
    i_prog.xfer(w, 32, e, r);
    cyc(10);
  endtask : ins

  task automatic wait_idle(output int n);
    n = 0;
    while (busy === 1'b1 && n < 5000) begin
      cyc(1);
      n++;
    end
  endtask : wait_idle

  task automatic pin_pulse();
    reset_pin_n = 1'b1;
    cyc(10);
    check({7'h00, mode}, 8'h00);
    reset_pin_n = 1'b0;
    cyc(16);
  endtask : pin_pulse

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  //////////////////////////////////////////////////
  initial begin
    #3_000_000;
    bad_count++;
    summarize();
  end

  initial begin
    logic [7:0] e;
    logic [7:0] r;
    logic [7:0] d;
    logic [7:0] lo [4];
    logic [7:0] hi [4];
    int a;
    int n;
    int k;
    cyc(8);
    srst = 1'b0;
    cyc(4);
    check({6'h00, mode, sout_oe_n}, 8'h01);
    reset_pin_n = 1'b0;
    cyc(16); // power-up wait cut short, the core needs only its power-on count and the pin sync
    check({6'h00, mode, sout_oe_n}, 8'h02);
    ins(32'hC000_1055, e, r);
    check({7'h00, busy}, 8'h00);
    ins(32'hAC53_0000, e, r);
    check(e, 8'h53);
    $display("entry test done");

    ins(32'hAC80_0000, e, r);
    check({7'h00, busy}, 8'h01);
    wait_idle(n);
    check({6'h00, busy, n + 10 >= ER_LEN}, 8'h01);
    for (k = 0; k < 4; k++) begin
      a = $random(seed);
      ins({8'h20, 6'h00, a[9:0], 8'h00}, e, r);
      check(r, 8'hFF);
      ins({8'hA0, 8'h00, a[7:0], 8'h00}, e, r);
      check(r, 8'hFF);
    end
    $display("erase test done");

    a = $random(seed) & 32'hFF;
    for (k = 0; k < 2; k++) begin
      d = 8'($random(seed)) & 8'h7F;
      ins({8'hC0, 8'h00, a[7:0], d}, e, r);
      ee_m[a] = d;
      ins({8'hA0, 8'h00, a[7:0], 8'h00}, e, r);
      check(r, 8'hFF);
      wait_idle(n);
      ins({8'hA0, 8'h00, a[7:0], 8'h00}, e, r);
      check(r, ee_m[a]);
    end
    $display("eeprom test done");

    for (k = 0; k < 4; k++) begin
      lo[k] = 8'($random(seed)) & 8'h7F;
      hi[k] = 8'($random(seed)) & 8'h7F;
      ins({8'h40, 8'h00, 1'b0, k[6:0], lo[k]}, e, r);
      ins({8'h48, 8'h00, 1'b0, k[6:0], hi[k]}, e, r);
    end
    a = ($random(seed) & 32'h7) * 128;
    ins({8'h4C, 6'h00, a[9:7], 7'h00, 8'h00}, e, r);
    ins({8'h20, 6'h00, a[9:0] + 10'h001, 8'h00}, e, r);
    check(r, 8'hFF);
    wait_idle(n);
    for (k = 0; k < 4; k++) begin
      ins({8'h20, 6'h00, a[9:0] + k[9:0], 8'h00}, e, r);
      check(r, lo[k]);
      ins({8'h28, 6'h00, a[9:0] + k[9:0], 8'h00}, e, r);
      check(r, hi[k]);
    end
    ins({8'h20, 6'h00, a[9:0] ^ 10'h080, 8'h00}, e, r);
    check(r, 8'hFF);
    $display("flash page test done");

    a = 0;
    pin_pulse();
    ins({8'hC0, 8'h00, 8'h00, 8'h11}, e, r);
    check({7'h00, busy}, 8'h00);
    i_prog.xfer(32'hFFFF_FFFF, 5, e, r);
    cyc(10);
    pin_pulse();
    ins(32'hAC53_0000, e, r);
    check(e, 8'h53);
    ins(32'hA000_0000, e, r);
    check(r, ee_m.exists(a) ? ee_m[a] : 8'hFF);
    $display("resync test done");

    srst = 1'b1;
    strap_n = 1'b0;
    reset_pin_n = 1'b1;
    cyc(8);
    srst = 1'b0;
    cyc(12);
    check({6'h00, mode, sout_oe_n}, 8'h02);
    strap_n = 1'b1;
    cyc(8);
    ins(32'hAC53_0000, e, r);
    check(e, 8'h53);
    check({6'h00, mode, sout_oe_n}, 8'h02);
    $display("strap test done");
    summarize();
  end
endmodule : test_spsmp_serial_prog

`default_nettype wire
